//--- logic/ucmd_phy_cmd.sv
// Command layer of a low pin count USB transceiver, device end.
// Assumes the link clock and all analog levels arrive unsynchronised;
// the register file sits outside and answers reads combinationally.
//
// Contract
// R1 - Link idles the data bus at zero, the no-operation value.
// R2 - Nonzero command byte; top two bits pick transmit, write or read.
// R3 - Next is raised on acceptance; only then may data bytes follow.
// R4 - Link never sends a command byte outside the defined encodings.
// R5 - Transmit with zero payload has no identifier; data follows acceptance.
// R6 - Transmit with nonzero low nibble carries the packet identifier.
// R7 - Write payload 101111 is extended: full address byte, then data.
// R8 - Other writes use the six-bit payload address; data after acceptance.
// R9 - Read payload 101111 is extended: address byte before data returns.
// R10 - Other reads return the register at the six-bit payload address.
// R11 - Status is sent by raising direction and driving a status byte.
// R12 - Any status field change sends a new status byte automatically.
// R13 - Link accepts status bytes at any time, also back to back.
// R14 - Status may be skipped on low-power exit if change already vanished.
// R15 - Status bits: line state, bus voltage, receive event, id level.
// R16 - Bit seven flags an enabled B-valid edge, otherwise zero.
// R17 - Line state follows the data lines; changes send status.
// R18 - Peripheral line state codes for full, high speed and chirp.
// R19 - Host line state codes for low, full, high speed and chirp.
// R20 - Dual-role link picks the encoding table of its current role.
// R21 - Direction high forces next low; link drives bus low after release.
// R22 - Direction raised during a register operation aborts it.
// R23 - Receive event codes: none, active, active with error, disconnect.
// R24 - Bus voltage codes from below session end to above valid.
// R25 - Link holds a command byte until next shows acceptance.
`timescale 1ns/1ps
module ucmd_phy_cmd (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 ulpi_clk,
  input  wire logic [7:0]           ulpi_data_in,
  output logic [7:0]                ulpi_data_out,
  output logic                      ulpi_data_oe,
  output logic                      dir,
  output logic                      nxt,
  input  wire logic                 stp,
  input  wire ucmd_pkg::ucmd_line_t line_in,
  input  wire ucmd_pkg::ucmd_cfg_t  cfg,
  input  wire logic [1:0]           vbus_state,
  input  wire logic [1:0]           rx_event,
  input  wire logic                 low_power,
  output logic                      reg_we,
  output logic                      reg_re,
  output logic [7:0]                reg_addr,
  output logic [7:0]                reg_wdata,
  input  wire logic [7:0]           reg_rdata,
  output logic                      op_abort,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output ucmd_pkg::ucmd_tx_t        tx_data,
  output logic                      tx_end
);
  import ucmd_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [UCMD_SYNC_W-1:0] raw_in;
  logic [UCMD_SYNC_W-1:0] s1;
  logic [UCMD_SYNC_W-1:0] s2;
  logic [UCMD_SYNC_W-1:0] s3;
  logic [UCMD_SYNC_W-1:0] filt;
  logic [UCMD_SYNC_W-1:0] next_filt;

  assign raw_in = {ulpi_clk, stp, ulpi_data_in, line_in};

  // Three stages; a change is believed once stages two and three agree
  generate
    for (genvar i = 0; i < UCMD_SYNC_W; i++) begin : g_sync
      assign next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          s1[i]   <= 1'b0;
          s2[i]   <= 1'b0;
          s3[i]   <= 1'b0;
          filt[i] <= 1'b0;
        end else begin
          s1[i]   <= raw_in[i];
          s2[i]   <= s1[i];
          s3[i]   <= s2[i];
          filt[i] <= next_filt[i];
        end
      end
    end
  endgenerate

  ucmd_line_t lines;
  logic [7:0] din;
  logic       stp_s;
  logic       lrise;

  assign lines = filt[5:0];
  assign din   = filt[13:6];
  assign stp_s = filt[14];
  // Link edge seen once per link period; bus sampled with it
  assign lrise = next_filt[15] && !filt[15];

  // ----------------------------------------
  // Status byte assembly
  // ----------------------------------------
  // Role-dependent line state; used for status and its check
  function automatic logic [1:0] line_code(input ucmd_cfg_t c, input ucmd_line_t l);
    logic host;
    logic chirp;
    host  = c.dp_pulldown && c.dm_pulldown;
    chirp = host ? (c.opmode == UCMD_OPM_CHIRP) : c.term_select;
    if (c.xcvr_select != UCMD_XS_HS) begin
      line_code = {l.dm, l.dp}; // [R18] [R19]
    end else if (l.squelch) begin
      line_code = UCMD_LS_SQUELCH;
    end else if (chirp && !l.hs_diff) begin
      line_code = UCMD_LS_DIFF_LO;
    end else begin
      line_code = UCMD_LS_ACTIVE;
    end
  endfunction : line_code

  logic       alt_pend;
  logic       next_alt_pend;
  logic       bv_prev;
  logic [7:0] stat_now;
  logic [7:0] last_sent;
  logic [7:0] next_last_sent;
  logic       pend;
  logic       send_ok;

  // Fields packed in fixed order; vbus and rx codes pass as given
  always_comb begin
    stat_now = UCMD_STAT_RST;
    stat_now[UCMD_ST_LINE +: 2] = line_code(cfg, lines); // [R15] [R17]
    stat_now[UCMD_ST_VBUS +: 2] = vbus_state;            // [R24]
    stat_now[UCMD_ST_RXEV +: 2] = rx_event;              // [R23]
    stat_now[UCMD_ST_ID]        = lines.id_pin;
    stat_now[UCMD_ST_ALT]       = alt_pend;              // [R16]
  end

  // Compare against last sent byte, so a change that reverts during
  // low power leaves nothing to send
  assign pend    = (stat_now != last_sent);  // [R12]
  assign send_ok = pend && !low_power;       // [R14]

  // ----------------------------------------
  // Bus engine
  // ----------------------------------------
  ucmd_state_t state;
  ucmd_state_t next_state;
  logic [7:0]  cmd_q;
  logic [7:0]  next_cmd;
  logic        next_nxt;
  logic        next_dir;
  logic        next_oe;
  logic [7:0]  next_dout;
  logic [7:0]  next_addr;
  logic [7:0]  next_wdata;
  logic        next_we;
  logic        next_re;
  logic        next_abort;
  logic        next_tx_end;
  logic        push;
  ucmd_tx_t    push_data;
  logic        buf_ready;
  logic [1:0]  buf_level;
  logic [1:0]  lvl_after;

  // Fill level after this cycle's push; nxt only offered with room
  assign lvl_after = 2'(buf_level + {1'b0, push});

  // Next values, decided only at a link edge
  always_comb begin
    next_state     = state;
    next_cmd       = cmd_q;
    next_nxt       = nxt;
    next_dir       = dir;
    next_oe        = ulpi_data_oe;
    next_dout      = ulpi_data_out;
    next_addr      = reg_addr;
    next_wdata     = reg_wdata;
    next_we        = 1'b0;
    next_re        = 1'b0;
    next_abort     = 1'b0;
    next_tx_end    = 1'b0;
    next_last_sent = last_sent;
    push           = 1'b0;
    push_data      = '0;
    if (lrise) begin
      unique case (state)
        S_IDLE: begin
          if (send_ok) begin
            next_dir   = 1'b1; // [R11]
            next_state = S_STURN;
          end else if (din != UCMD_BUS_IDLE) begin
            next_cmd   = din;  // [R2]
            next_nxt   = (din[7:6] != UCMD_TY_TX) || buf_ready; // [R3]
            next_state = S_CMD;
          end
        end
        S_CMD: begin
          if (nxt) begin
            // Command taken at this edge; dispatch on its type
            if (cmd_q[7:6] == UCMD_TY_TX) begin
              push          = (cmd_q[5:0] != UCMD_NOPID); // [R5] [R6]
              push_data.hdr = 1'b1;
              push_data.data = {4'h0, cmd_q[3:0]};        // [R6]
              next_nxt      = 1'b0;
              next_state    = S_TX;
            end else if (send_ok) begin
              next_nxt   = 1'b0; // [R22]
              next_dir   = 1'b1;
              next_abort = 1'b1;
              next_state = S_STURN;
            end else if (cmd_q[7:6] == UCMD_TY_WR) begin
              next_addr  = {2'h0, cmd_q[5:0]};                          // [R8]
              next_state = (cmd_q[5:0] == UCMD_EXT) ? S_WADDR : S_WDATA; // [R7]
            end else if (cmd_q[5:0] == UCMD_EXT) begin
              next_state = S_RADDR; // [R9]
            end else begin
              next_addr  = {2'h0, cmd_q[5:0]}; // [R10]
              next_re    = 1'b1;
              next_nxt   = 1'b0;
              next_dir   = 1'b1;
              next_state = S_RTURN;
            end
          end else begin
            next_nxt = buf_ready; // [R25]
          end
        end
        S_TX: begin
          if (stp_s) begin
            next_nxt    = 1'b0;
            next_tx_end = 1'b1;
            next_state  = S_IDLE;
          end else begin
            if (nxt) begin
              push           = 1'b1; // [R5]
              push_data.data = din;
            end
            next_nxt = (lvl_after < 2'(UCMD_BUF_D));
          end
        end
        S_WADDR, S_WDATA, S_RADDR: begin
          if (send_ok) begin
            next_nxt   = 1'b0; // [R22]
            next_dir   = 1'b1;
            next_abort = 1'b1;
            next_state = S_STURN;
          end else if (nxt && state == S_WADDR) begin
            next_addr  = din; // [R7]
            next_state = S_WDATA;
          end else if (nxt && state == S_WDATA) begin
            next_wdata = din; // [R8]
            next_we    = 1'b1;
            next_nxt   = 1'b0;
            next_state = S_IDLE;
          end else if (nxt) begin
            next_addr  = din; // [R9]
            next_re    = 1'b1;
            next_nxt   = 1'b0;
            next_dir   = 1'b1;
            next_state = S_RTURN;
          end
        end
        S_RTURN: begin
          next_oe    = 1'b1;
          next_dout  = reg_rdata; // [R10]
          next_state = S_RDATA;
        end
        S_RDATA: begin
          // Back to back status if the byte already waits
          if (send_ok) begin
            next_dout      = stat_now;
            next_last_sent = stat_now;
            next_state     = S_STURN;
          end else begin
            next_dir   = 1'b0;
            next_oe    = 1'b0;
            next_state = S_IDLE;
          end
        end
        S_STURN: begin
          if (!ulpi_data_oe) begin
            next_oe        = 1'b1;
            next_dout      = stat_now; // [R11] [R15]
            next_last_sent = stat_now;
          end else if (send_ok) begin
            next_dout      = stat_now; // [R12]
            next_last_sent = stat_now;
          end else begin
            next_dir   = 1'b0;
            next_oe    = 1'b0;
            next_state = S_IDLE;
          end
        end
        default: begin
          next_state = S_IDLE;
          next_nxt   = 1'b0;
          next_dir   = 1'b0;
          next_oe    = 1'b0;
        end
      endcase
    end
  end

  // Alternate flag: an enabled edge sets it, sending clears, set wins
  logic bv_rise;
  logic bv_fall;
  assign bv_rise = lines.bvalid && !bv_prev && cfg.bvalid_rise_en;
  assign bv_fall = !lines.bvalid && bv_prev && cfg.bvalid_fall_en;
  always_comb begin
    next_alt_pend = alt_pend;
    if (next_last_sent != last_sent || (state == S_STURN && next_oe && !ulpi_data_oe)) begin
      next_alt_pend = 1'b0;
    end
    if (bv_rise || bv_fall) begin
      next_alt_pend = 1'b1; // [R16]
    end
  end

  // Registers only; all decisions above except nxt, masked here by next_dir
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state         <= S_IDLE;
      cmd_q         <= UCMD_BUS_IDLE;
      nxt           <= 1'b0;
      dir           <= 1'b0;
      ulpi_data_oe  <= 1'b0;
      ulpi_data_out <= UCMD_BUS_IDLE;
      reg_addr      <= 8'h00;
      reg_wdata     <= 8'h00;
      reg_we        <= 1'b0;
      reg_re        <= 1'b0;
      op_abort      <= 1'b0;
      tx_end        <= 1'b0;
      last_sent     <= UCMD_STAT_RST;
      alt_pend      <= 1'b0;
      bv_prev       <= 1'b0;
    end else begin
      state         <= next_state;
      cmd_q         <= next_cmd;
      nxt           <= next_nxt && !next_dir; // [R21]
      dir           <= next_dir;
      ulpi_data_oe  <= next_oe;
      ulpi_data_out <= next_dout;
      reg_addr      <= next_addr;
      reg_wdata     <= next_wdata;
      reg_we        <= next_we;
      reg_re        <= next_re;
      op_abort      <= next_abort;
      tx_end        <= next_tx_end;
      last_sent     <= next_last_sent;
      alt_pend      <= next_alt_pend;
      bv_prev       <= lines.bvalid;
    end
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  ucmd_buf u_buf (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (push_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data),
    .level     (buf_level)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_dir_nxt_low: assert property (dir |-> !nxt) // [R21]
    else $error("nxt high while dir held");
  a_drive_dir: assert property (ulpi_data_oe |-> dir) // [R11]
    else $error("data driven without dir");
  a_stat_sent: assert property (lrise && state == S_IDLE && send_ok |=> dir) // [R12]
    else $error("status change not reported");
  a_stat_value: assert property ($rose(ulpi_data_oe) && state == S_STURN
      |-> ulpi_data_out == last_sent && ulpi_data_out[UCMD_ST_ID] == $past(lines.id_pin)) // [R15]
    else $error("status byte wrong");
  a_write_accept: assert property (reg_we |-> $past(nxt) && $past(state == S_WDATA)) // [R8]
    else $error("write without acceptance");
  a_imm_read: assert property (reg_re && $past(state == S_CMD)
      |-> reg_addr == {2'h0, $past(cmd_q[5:0])} && dir) // [R10]
    else $error("immediate read address wrong");
  a_ext_read: assert property (reg_re && $past(state == S_RADDR)
      |-> reg_addr == $past(din)) // [R9]
    else $error("extended read address wrong");
  a_pid_hdr: assert property (push && push_data.hdr
      |-> cmd_q[5:0] != UCMD_NOPID && push_data.data[3:0] == cmd_q[3:0]) // [R6]
    else $error("identifier byte wrong");
  a_abort_dir: assert property (op_abort |-> dir && !nxt ##1 dir) // [R22]
    else $error("abort without taking bus");
  a_fs_line: assert property (cfg.xcvr_select == 2'h1 && cfg.term_select
      |-> stat_now[1:0] == {lines.dm, lines.dp}) // [R18]
    else $error("full speed line code wrong");

endmodule : ucmd_phy_cmd

//--- shared/ucmd_pkg.sv
// Package for the command layer: constants, state codes and carriers.
// Assumes all users import it whole; no clocks or logic live here.
package ucmd_pkg;

  // ----------------------------------------
  // Command byte layout
  // ----------------------------------------
  localparam logic [1:0] UCMD_TY_IDLE = 2'h0;
  localparam logic [1:0] UCMD_TY_TX   = 2'h1;
  localparam logic [1:0] UCMD_TY_WR   = 2'h2;
  localparam logic [1:0] UCMD_TY_RD   = 2'h3;
  localparam logic [5:0] UCMD_EXT     = 6'h2f;
  localparam logic [5:0] UCMD_NOPID   = 6'h00;
  localparam logic [7:0] UCMD_BUS_IDLE = 8'h00;

  // ----------------------------------------
  // Status byte fields and codes
  // ----------------------------------------
  localparam int UCMD_ST_LINE = 0;
  localparam int UCMD_ST_VBUS = 2;
  localparam int UCMD_ST_RXEV = 4;
  localparam int UCMD_ST_ID   = 6;
  localparam int UCMD_ST_ALT  = 7;
  localparam logic [1:0] UCMD_LS_SQUELCH = 2'h0;
  localparam logic [1:0] UCMD_LS_ACTIVE  = 2'h1;
  localparam logic [1:0] UCMD_LS_DIFF_LO = 2'h2;
  localparam logic [1:0] UCMD_XS_HS      = 2'h0;
  localparam logic [1:0] UCMD_OPM_CHIRP  = 2'h2;

  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam logic [7:0] UCMD_STAT_RST = 8'h00;
  localparam int         UCMD_SYNC_W   = 16;
  localparam int         UCMD_BUF_W    = 9;
  localparam int         UCMD_BUF_D    = 2;

  // One-hot states of the bus engine
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_CMD   = 9'h002,
    S_TX    = 9'h004,
    S_WADDR = 9'h008,
    S_WDATA = 9'h010,
    S_RADDR = 9'h020,
    S_RTURN = 9'h040,
    S_RDATA = 9'h080,
    S_STURN = 9'h100
  } ucmd_state_t;

  // Transmit stream word: header marks a packet identifier byte
  typedef struct packed {
    logic       hdr;
    logic [7:0] data;
  } ucmd_tx_t;

  // Analog side status levels, all from outside the clock domain
  typedef struct packed {
    logic dp;
    logic dm;
    logic squelch;
    logic hs_diff;
    logic id_pin;
    logic bvalid;
  } ucmd_line_t;

  // Transceiver mode settings
  typedef struct packed {
    logic       dp_pulldown;
    logic       dm_pulldown;
    logic [1:0] xcvr_select;
    logic       term_select;
    logic [1:0] opmode;
    logic       bvalid_rise_en;
    logic       bvalid_fall_en;
  } ucmd_cfg_t;

endpackage : ucmd_pkg

//--- logic/ucmd_buf.sv
// Two-entry buffer for the transmit byte stream.
// Assumes one clock and reset shared with the command engine.
`timescale 1ns/1ps
module ucmd_buf (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire ucmd_pkg::ucmd_tx_t in_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output ucmd_pkg::ucmd_tx_t      out_data,
  output logic [1:0]              level
);
  import ucmd_pkg::*;

  ucmd_tx_t   mem [UCMD_BUF_D];
  logic       wr_idx;
  logic       rd_idx;
  logic [1:0] count;
  logic       push;
  logic       pop;

  // ----------------------------------------
  // Handshakes
  // ----------------------------------------
  assign in_ready  = (count != 2'(UCMD_BUF_D));
  assign out_valid = (count != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_idx];
  assign level     = count;

  // Storage and pointers; full refuses writes so no word is overwritten
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      count  <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      if (push) begin
        mem[wr_idx] <= in_data;
        wr_idx      <= ~wr_idx;
      end
      if (pop) begin
        rd_idx <= ~rd_idx;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule : ucmd_buf

//--- tb/ucmd_link_model.sv
// Link side model of the low pin count bus: clock, data byte and stop.
// Assumes the bench resolves the bus level from both ends' enables.
`timescale 1ns/1ps
module ucmd_link_model (
  output logic       ulpi_clk,
  output logic [7:0] lk_d,
  output logic       stp,
  input  wire logic  dir,
  input  wire logic  nxt
);
  // ----------------------------------------
  // Clock and idle levels
  // ----------------------------------------
  // Free running clock, odd offset keeps its edges a fixed 1.3 ns off the system clock edges
  initial begin
    ulpi_clk = 1'b0;
    lk_d     = 8'h00;
    stp      = 1'b0;
    #13.3;
    forever #40 ulpi_clk = ~ulpi_clk;
  end

  // ----------------------------------------
  // Byte transfers
  // ----------------------------------------
  // Drive on the falling edge, far from where the device samples
  task automatic send(input logic [7:0] b);
    while (dir !== 1'b0) @(posedge ulpi_clk);
    @(negedge ulpi_clk) lk_d <= b;
    do @(posedge ulpi_clk); while (!(nxt === 1'b1 && dir === 1'b0));
  endtask : send

  // Back to the no-operation value
  task automatic idle();
    @(negedge ulpi_clk) lk_d <= 8'h00;
  endtask : idle

  // One cycle of stop with the bus at idle ends a packet
  task automatic stop();
    @(negedge ulpi_clk) begin
      lk_d <= 8'h00;
      stp  <= 1'b1;
    end
    @(negedge ulpi_clk) stp <= 1'b0;
  endtask : stop
endmodule : ucmd_link_model

//--- tb/ucmd_phy_cmd_tb.sv
// Self-checking bench of the command layer, link model on the far side.
// Assumes a register file echoing the inverted address on reads.
`timescale 1ns/1ps
module ucmd_phy_cmd_tb;
  import ucmd_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ulpi_clk, stp, dir, nxt, ulpi_data_oe, reg_we, reg_re, op_abort;
  logic tx_valid, tx_ready, tx_end, stall, low_power;
  logic [7:0] ulpi_data_in, ulpi_data_out, lk_d, reg_addr, reg_wdata, reg_rdata;
  logic [1:0] vbus_state, rx_event;
  ucmd_line_t line_in;
  ucmd_cfg_t  cfg;
  ucmd_tx_t   tx_data;
  logic [15:0] exp_q [4][$];
  logic [1:0]  rxc [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  int n_errors = 0;
  int tests_run = 0;
  int seed = 32'hfd17bfcf;

  // ----------------------------------------
  // Clock, wiring and instances
  // ----------------------------------------
  always #4 sys_clk = ~sys_clk;
  // Undriven bus shows the inverse of the link's last byte
  assign ulpi_data_in = ulpi_data_oe ? ulpi_data_out : (dir ? ~lk_d : lk_d);
  assign reg_rdata = ~reg_addr;
  always @(posedge sys_clk) tx_ready <= stall ? 1'b0 : 1'($random(seed));
  ucmd_link_model lk (.ulpi_clk(ulpi_clk), .lk_d(lk_d), .stp(stp), .dir(dir), .nxt(nxt));
  ucmd_phy_cmd DUT (.sys_clk(sys_clk), .nrst(nrst), .ulpi_clk(ulpi_clk),
    .ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe),
    .dir(dir), .nxt(nxt), .stp(stp), .line_in(line_in), .cfg(cfg), .vbus_state(vbus_state),
    .rx_event(rx_event), .low_power(low_power), .reg_we(reg_we), .reg_re(reg_re),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .op_abort(op_abort),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_end(tx_end));

  // ----------------------------------------
  // Scoreboard
  // ----------------------------------------
  task automatic chk(input int k, input logic [15:0] seen);
    logic [15:0] e;
    tests_run++;
    e = (exp_q[k].size() != 0) ? exp_q[k].pop_front() : 16'hdead;
    if (seen !== e) begin
      n_errors++;
      $display("mismatch out%0d expected %h seen %h", k, e, seen);
    end
  endtask : chk

  // Status byte the device should send for the present inputs
  function automatic logic [7:0] stat();
    logic [1:0] ls;
    logic       chirp;
    chirp = (cfg.dp_pulldown && cfg.dm_pulldown) ? (cfg.opmode == UCMD_OPM_CHIRP)
                                                 : cfg.term_select;
    ls = {line_in.dm, line_in.dp};
    if (cfg.xcvr_select == UCMD_XS_HS)
      ls = line_in.squelch ? UCMD_LS_SQUELCH
         : (chirp && !line_in.hs_diff) ? UCMD_LS_DIFF_LO : UCMD_LS_ACTIVE;
    return {1'b0, line_in.id_pin, rx_event, vbus_state, ls};
  endfunction : stat

  // Pulses and stream words are seen one system cycle after launch
  always @(posedge sys_clk) begin
    if (reg_we === 1'b1) chk(1, {reg_addr, reg_wdata});
    if (tx_valid === 1'b1 && tx_ready === 1'b1) chk(2, {7'h00, tx_data});
    if (tx_end === 1'b1) chk(0, 16'h0000);
    if (op_abort === 1'b1) chk(0, 16'h0001);
  end
  // A driven bus byte stands one link cycle, so take it at each rise
  always @(posedge ulpi_clk) begin
    if (dir === 1'b1 && ulpi_data_oe === 1'b1) chk(3, {8'h00, ulpi_data_out});
  end

  // ----------------------------------------
  // Stimulus tasks
  // ----------------------------------------
  task automatic reg_op(input logic rd, input logic ext);
    logic [7:0] a, d;
    a = $random(seed);
    d = $random(seed);
    if (!ext) a = {2'h0, (a[5:0] == UCMD_EXT) ? 6'h2e : a[5:0]};
    if (rd) exp_q[3].push_back({8'h00, ~a});
    else exp_q[1].push_back({a, d});
    lk.send({rd ? UCMD_TY_RD : UCMD_TY_WR, ext ? UCMD_EXT : a[5:0]});
    if (ext) lk.send(a);
    if (!rd) lk.send(d);
    lk.idle();
    repeat (6) @(posedge ulpi_clk);
  endtask : reg_op

  // Packet with optional identifier; header word only when it has one
  task automatic tx_pkt(input logic [7:0] c, input int n);
    logic [7:0] d;
    if (c[3:0] != 4'h0) exp_q[2].push_back({7'h00, 1'b1, 4'h0, c[3:0]});
    lk.send(c);
    repeat (n) begin
      d = $random(seed);
      exp_q[2].push_back({8'h00, d});
      lk.send(d);
    end
    exp_q[0].push_back(16'h0000);
    lk.stop();
    repeat (6) @(posedge ulpi_clk);
  endtask : tx_pkt

  task automatic test_done();
    for (int k = 0; k < 4; k++) n_errors += exp_q[k].size();
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    #200000;
    n_errors++;
    test_done();
  end

  initial begin
    line_in = 6'h2a; // Full speed J, squelch on, id high
    cfg = '0;
    cfg.xcvr_select = 2'h1;
    cfg.term_select = 1'b1;
    vbus_state = 2'h2;
    rx_event = 2'h0;
    tx_ready = 1'b0;
    stall = 1'b0;
    low_power = 1'b0;
    exp_q[3].push_back({8'h00, stat()});
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge ulpi_clk);
    for (int j = 0; j < 8; j++) reg_op(j[0], j[1]);
    // Status change as the command is taken aborts it; the link retries
    lk.send({UCMD_TY_WR, UCMD_EXT});
    @(posedge sys_clk) vbus_state <= ~vbus_state;
    @(negedge sys_clk) exp_q[3].push_back({8'h00, stat()});
    exp_q[0].push_back(16'h0001);
    lk.idle();
    reg_op(1'b0, 1'b1);
    stall = 1'b1; // Receiver stalls so the buffer fills and acceptance is refused
    fork
      begin
        repeat (250) @(posedge sys_clk);
        stall <= 1'b0;
      end
    join_none
    tx_pkt(8'h43, 6);
    tx_pkt(8'h40, 5);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) begin
        vbus_state <= 2'(i);
        rx_event   <= rxc[i];
      end
      @(negedge sys_clk) exp_q[3].push_back({8'h00, stat()});
      repeat (8) @(posedge ulpi_clk);
      @(posedge sys_clk) {line_in.dm, line_in.dp} <= 2'(i + 2);
      @(negedge sys_clk) exp_q[3].push_back({8'h00, stat()});
      repeat (8) @(posedge ulpi_clk);
    end
    // Change that reverts inside low power leaves nothing to report
    @(posedge sys_clk) low_power <= 1'b1;
    @(posedge sys_clk) rx_event <= 2'h1;
    repeat (8) @(posedge ulpi_clk);
    @(posedge sys_clk) rx_event <= 2'h0;
    @(posedge sys_clk) low_power <= 1'b0;
    repeat (8) @(posedge ulpi_clk);
    // Squelch levels are ignored at full speed, so no status yet
    @(posedge sys_clk) {line_in.squelch, line_in.hs_diff} <= 2'h0;
    repeat (8) @(posedge ulpi_clk);
    @(posedge sys_clk) cfg.xcvr_select <= UCMD_XS_HS;
    @(negedge sys_clk) exp_q[3].push_back({8'h00, stat()});
    repeat (8) @(posedge ulpi_clk);
    @(posedge sys_clk) cfg <= {2'h3, 2'h2, 1'b1, 4'h0};
    @(negedge sys_clk) exp_q[3].push_back({8'h00, stat()});
    repeat (8) @(posedge ulpi_clk);
    // Host chirp, then an enabled B-valid rise flags bit seven once
    @(posedge sys_clk) cfg <= {2'h3, UCMD_XS_HS, 1'b0, UCMD_OPM_CHIRP, 2'h2};
    @(negedge sys_clk) exp_q[3].push_back({8'h00, stat()});
    repeat (8) @(posedge ulpi_clk);
    @(posedge sys_clk) line_in.bvalid <= 1'b1;
    @(negedge sys_clk) exp_q[3].push_back({8'h00, stat() | 8'h80});
    exp_q[3].push_back({8'h00, stat()});
    repeat (8) @(posedge ulpi_clk);
    reg_op(1'b0, 1'b0);
    test_done();
  end
endmodule : ucmd_phy_cmd_tb
